// ==== inc/pwm_timer_pkg.sv ====
// ============================================================
// Shared constants and types of the multichannel PWM timer
package pwm_timer_pkg;

	// ============================================================
	// Sizes
	localparam int CH_NUM = 8;
	localparam int PAIR_NUM = 4;
	localparam int FAULT_NUM = 4;
	localparam int CNT_W = 16;
	localparam int FRAC_W = 5;
	localparam int LFREQ_W = 5;
	localparam int DT_W = 6;
	localparam int DTC_W = DT_W + 4;
	localparam int FILT_LEN = 4;
	localparam int ADDR_W = 8;
	localparam int LVL_W = 2;

	// ============================================================
	// Register byte offsets
	localparam logic [ADDR_W-1:0] OFF_CTRL = 8'h00;
	localparam logic [ADDR_W-1:0] OFF_INIT = 8'h04;
	localparam logic [ADDR_W-1:0] OFF_MOD = 8'h08;
	localparam logic [ADDR_W-1:0] OFF_MODMIR = 8'h0C;
	localparam logic [ADDR_W-1:0] OFF_OUTMASK = 8'h10;
	localparam logic [ADDR_W-1:0] OFF_OUTEN = 8'h14;
	localparam logic [ADDR_W-1:0] OFF_PAIR = 8'h18;
	localparam logic [ADDR_W-1:0] OFF_FAULT = 8'h1C;
	localparam logic [ADDR_W-1:0] OFF_DEADT = 8'h20;
	localparam logic [ADDR_W-1:0] OFF_HCR = 8'h24;
	localparam logic [ADDR_W-1:0] OFF_STAT = 8'h28;
	localparam logic [ADDR_W-1:0] OFF_CHEN = 8'h2C;
	localparam logic [ADDR_W-1:0] OFF_LEVEL = 8'h30;
	localparam logic [ADDR_W-1:0] OFF_PINS = 8'h34;
	localparam logic [ADDR_W-1:0] OFF_RELSEL = 8'h38;
	localparam logic [ADDR_W-1:0] OFF_MATCH = 8'h40;
	localparam logic [ADDR_W-1:0] OFF_MATCHMIR = 8'h60;
	localparam int BLK_LSB = 5;
	localparam int IDX_LSB = 2;
	localparam int IDX_W = 3;

	// ============================================================
	// Field positions
	localparam int CTRL_RUN = 0;
	localparam int CTRL_GTB = 1;
	localparam int CTRL_WPEN = 2;
	localparam int CTRL_SWSEL = 3;
	localparam int CTRL_LOAD_OK_BIT = 4;
	localparam int CTRL_SWTRIG = 5;
	localparam int CTRL_LF_LSB = 8;
	localparam int RELSEL_HC = 8;
	localparam int STAT_TOF = 8;
	localparam int STAT_FAULT = 9;
	localparam int PINS_OUT_LSB = 8;
	localparam int CHEN_DMA_LSB = 8;
	localparam int MIR_VAL_LSB = 5;
	localparam int PAIR_FW = 4;
	localparam int FAULT_FW = 4;
	localparam int DT_FW = 8;
	localparam logic [1:0] DT_PS_X4 = 2'h2;
	localparam logic [1:0] DT_PS_X16 = 2'h3;
	localparam int DT_SH_X4 = 2;
	localparam int DT_SH_X16 = 4;

	// ============================================================
	// Encodings
	localparam logic [LVL_W-1:0] LVL_NONE = 2'h0;
	localparam logic [LVL_W-1:0] LVL_LOW = 2'h1;
	localparam logic [LVL_W-1:0] LVL_HIGH = 2'h2;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// ============================================================
	// Field groups
	typedef struct packed {
		logic dt_en;
		logic comp;
		logic combine;
	} pair_cfg_t;

	typedef struct packed {
		logic filt;
		logic act_low;
		logic en;
	} fault_cfg_t;

	typedef struct packed {
		logic [1:0] prescale;
		logic [DT_W-1:0] value;
	} dt_cfg_t;

endpackage

// ==== verilog/pwm_timer.sv ====
// Behaviour
// RULE1: four fault inputs: enable, polarity, filter each
// RULE2: global time base output can be switched
// RULE3: masked channel forced to inactive level
// RULE4: output enable cleared releases pin for input
// RULE5: software trigger selectable as sync source
// RULE6: write protection guards configuration registers
// RULE7: DMA and irq enable with flag: DMA
// RULE8: load-OK bit permits buffered values at reload
// RULE9: half-cycle value applied at next load
// RULE10: load frequency 0..31 thins reload points
// RULE11: dead time prescaler and value per pair
// RULE12: period dithering uses modulo mirror register
// RULE13: edge dithering uses match mirror registers
// RULE14: channel input level readable after sampling
// RULE15: final channel output level readable
// RULE16: combined pair outputs complementary or identical
// RULE17: dead time only in complementary combined pairs
// RULE18: asymmetric combined delays first edge by match
// RULE19: initial, modulo and match values in ticks
// RULE20: level select none, low-true, high-true
// RULE21: reload points include channel matches
// RULE22: counter wraps to initial value, overflow flag
//
// Local design decisions: register access over AXI4-Lite and the register addresses.
`timescale 1ns/1ns
`default_nettype none
module pwm_timer #(
	parameter int CNT_W = pwm_timer_pkg::CNT_W,
	parameter int FILT_LEN = pwm_timer_pkg::FILT_LEN
) (
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// AXI4-Lite write
	input wire logic [pwm_timer_pkg::ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// AXI4-Lite read
	input wire logic [pwm_timer_pkg::ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// Channel pins
	input wire logic [pwm_timer_pkg::CH_NUM-1:0] ch_in,
	output logic [pwm_timer_pkg::CH_NUM-1:0] ch_out,
	output logic [pwm_timer_pkg::CH_NUM-1:0] ch_oe,
	// Fault inputs
	input wire logic [pwm_timer_pkg::FAULT_NUM-1:0] fault_in,
	// Time base, DMA and channel events
	output logic gtb_out,
	output logic [pwm_timer_pkg::CH_NUM-1:0] dma_req,
	input wire logic [pwm_timer_pkg::CH_NUM-1:0] dma_ack,
	output logic [pwm_timer_pkg::CH_NUM-1:0] chan_irq
);

	localparam int NC = pwm_timer_pkg::CH_NUM;
	localparam int NP = pwm_timer_pkg::PAIR_NUM;
	localparam int NF = pwm_timer_pkg::FAULT_NUM;
	localparam int AW = pwm_timer_pkg::ADDR_W;
	localparam int FW = pwm_timer_pkg::FRAC_W;
	localparam int FLT_CW = $clog2(FILT_LEN) + 1;
	localparam int IDX_W_L = pwm_timer_pkg::IDX_W;

	// ============================================================
	// State
	logic aw_full_q, w_full_q, awready_q, wready_q, bvalid_q, arready_q, rvalid_q;
	logic [1:0] bresp_q, rresp_q;
	logic [31:0] rdata_q, wdata_q;
	logic [3:0] wstrb_q;
	logic [AW-1:0] waddr_q;
	logic run_q, gtb_en_q, wpen_q, swsel_q, load_ok_bit_q;
	logic [pwm_timer_pkg::LFREQ_W-1:0] lfreq_q, lf_cnt_q;
	logic [CNT_W-1:0] init_buf_q, mod_buf_q, hcr_buf_q, init_q, mod_q, hcr_q, cnt_q;
	logic [FW-1:0] modfrac_buf_q, modfrac_q, pacc_q;
	logic pcar_q;
	logic [CNT_W-1:0] match_buf_q [NC];
	logic [CNT_W-1:0] match_q [NC];
	logic [FW-1:0] mfrac_buf_q [NC];
	logic [FW-1:0] mfrac_q [NC];
	logic [FW-1:0] eacc_q [NC];
	logic [NC-1:0] ecar_q, outmask_q, outen_q, flag_q, chie_q, dmae_q;
	logic [NC-1:0] in_s1_q, in_s2_q, out_q, oe_q, dma_q, irq_q;
	logic [NP*pwm_timer_pkg::PAIR_FW-1:0] pair_q;
	logic [NF*pwm_timer_pkg::FAULT_FW-1:0] fault_q;
	logic [NP*pwm_timer_pkg::DT_FW-1:0] deadt_q;
	logic [NC*pwm_timer_pkg::LVL_W-1:0] level_q;
	logic [pwm_timer_pkg::RELSEL_HC:0] relsel_q;
	logic tof_q, faultf_q, gtb_q;
	logic [NF-1:0] fflt_q;
	logic [FLT_CW-1:0] fcnt_q [NF];
	logic [pwm_timer_pkg::DTC_W-1:0] dead_q [NP];
	logic [NP-1:0] prev_q;

	// ============================================================
	// Helper functions
	function automatic logic [31:0] strb_mask(input logic [3:0] s);
		logic [31:0] m;
		m = '0;
		for (int b = 0; b < 4; b++) begin
			m[b*8 +: 8] = {8{s[b]}};
		end
		return m;
	endfunction

	function automatic logic in_blk(input logic [AW-1:0] a, input logic [AW-1:0] base);
		return a[AW-1:pwm_timer_pkg::BLK_LSB] == base[AW-1:pwm_timer_pkg::BLK_LSB];
	endfunction

	function automatic logic addr_ok(input logic [AW-1:0] a);
		return (a <= pwm_timer_pkg::OFF_RELSEL) || in_blk(a, pwm_timer_pkg::OFF_MATCH)
			|| in_blk(a, pwm_timer_pkg::OFF_MATCHMIR);
	endfunction

	// Configuration words that write protection guards
	function automatic logic is_prot(input logic [AW-1:0] a);
		return a == pwm_timer_pkg::OFF_INIT || a == pwm_timer_pkg::OFF_MOD
			|| a == pwm_timer_pkg::OFF_MODMIR || a == pwm_timer_pkg::OFF_PAIR
			|| a == pwm_timer_pkg::OFF_FAULT || a == pwm_timer_pkg::OFF_DEADT
			|| a == pwm_timer_pkg::OFF_LEVEL;
	endfunction

	// Effective match including the edge dither carry
	function automatic logic [CNT_W-1:0] m_eff(input int i);
		return match_q[i] + CNT_W'(ecar_q[i]);
	endfunction

	// Dead time in ticks: value times prescale
	function automatic logic [pwm_timer_pkg::DTC_W-1:0] dt_ticks(input pwm_timer_pkg::dt_cfg_t c);
		logic [pwm_timer_pkg::DTC_W-1:0] v;
		v = pwm_timer_pkg::DTC_W'(c.value);
		if (c.prescale == pwm_timer_pkg::DT_PS_X4) begin
			v = v << pwm_timer_pkg::DT_SH_X4;
		end else if (c.prescale == pwm_timer_pkg::DT_PS_X16) begin
			v = v << pwm_timer_pkg::DT_SH_X16;
		end
		return v;
	endfunction

	function automatic logic [31:0] rd_word(input logic [AW-1:0] a);
		logic [31:0] r;
		logic [IDX_W_L-1:0] ix;
		r = '0;
		ix = a[pwm_timer_pkg::IDX_LSB +: IDX_W_L];
		if (in_blk(a, pwm_timer_pkg::OFF_MATCH)) begin
			r = 32'(match_buf_q[ix]);
		end else if (in_blk(a, pwm_timer_pkg::OFF_MATCHMIR)) begin
			r = 32'({match_buf_q[ix], mfrac_buf_q[ix]});
		end else begin
			case (a)
				pwm_timer_pkg::OFF_CTRL: r = 32'({lfreq_q, 3'h0, load_ok_bit_q, swsel_q,
					wpen_q, gtb_en_q, run_q});
				pwm_timer_pkg::OFF_INIT: r = 32'(init_buf_q);
				pwm_timer_pkg::OFF_MOD: r = 32'(mod_buf_q);
				pwm_timer_pkg::OFF_MODMIR: r = 32'({mod_buf_q, modfrac_buf_q});
				pwm_timer_pkg::OFF_OUTMASK: r = 32'(outmask_q);
				pwm_timer_pkg::OFF_OUTEN: r = 32'(outen_q);
				pwm_timer_pkg::OFF_PAIR: r = 32'(pair_q);
				pwm_timer_pkg::OFF_FAULT: r = 32'(fault_q);
				pwm_timer_pkg::OFF_DEADT: r = 32'(deadt_q);
				pwm_timer_pkg::OFF_HCR: r = 32'(hcr_buf_q);
				pwm_timer_pkg::OFF_STAT: r = 32'({faultf_q, tof_q, flag_q});
				pwm_timer_pkg::OFF_CHEN: r = 32'({dmae_q, chie_q});
				pwm_timer_pkg::OFF_LEVEL: r = 32'(level_q);
				pwm_timer_pkg::OFF_PINS: r = 32'({out_q, in_s2_q}); // RULE14 RULE15
				pwm_timer_pkg::OFF_RELSEL: r = 32'(relsel_q);
				default: r = '0;
			endcase
		end
		return r;
	endfunction

	// ============================================================
	// Write decode
	logic do_wr, wr_ok, is_mir, sw_sync;
	logic [31:0] wmask, wword;
	logic [IDX_W_L-1:0] widx;
	assign do_wr = aw_full_q & w_full_q & ~bvalid_q;
	assign wr_ok = do_wr & addr_ok(waddr_q) & ~(wpen_q & is_prot(waddr_q)); // RULE6
	assign wmask = strb_mask(wstrb_q);
	assign wword = (rd_word(waddr_q) & ~wmask) | (wdata_q & wmask);
	assign widx = waddr_q[pwm_timer_pkg::IDX_LSB +: IDX_W_L];
	assign is_mir = in_blk(waddr_q, pwm_timer_pkg::OFF_MATCHMIR);
	assign sw_sync = wr_ok & (waddr_q == pwm_timer_pkg::OFF_CTRL)
		& wword[pwm_timer_pkg::CTRL_SWTRIG] & wword[pwm_timer_pkg::CTRL_SWSEL]; // RULE5

	// ============================================================
	// Counter, reload points and PWM waveform
	logic wrap, rp, take, load, fault_act;
	logic [NC-1:0] hits, raw;
	logic [NP-1:0] dt_use, dead_now;
	logic [NF-1:0] fsel;
	pwm_timer_pkg::pair_cfg_t pc;
	pwm_timer_pkg::fault_cfg_t fc;

	assign wrap = run_q & (cnt_q == mod_q + CNT_W'(pcar_q)); // RULE12
	assign rp = wrap | (|(hits & relsel_q[NC-1:0]))
		| (relsel_q[pwm_timer_pkg::RELSEL_HC] & run_q & (cnt_q == hcr_q)); // RULE21 RULE9
	assign take = rp & (lf_cnt_q == lfreq_q); // RULE10
	assign load = (take & load_ok_bit_q) | sw_sync; // RULE8
	assign fault_act = |fsel;

	// Match detection, pair waveforms and dead-time windows
	always_comb begin
		pc = '0;
		fc = '0;
		for (int i = 0; i < NC; i++) begin
			hits[i] = run_q & (cnt_q == m_eff(i)); // RULE13
		end
		for (int p = 0; p < NP; p++) begin
			pc = pwm_timer_pkg::pair_cfg_t'(pair_q[p*pwm_timer_pkg::PAIR_FW +: 3]);
			if (pc.combine) begin
				raw[2*p] = (cnt_q >= m_eff(2*p)) && (cnt_q < m_eff(2*p+1)); // RULE18
				raw[2*p+1] = pc.comp ? ~raw[2*p] : raw[2*p]; // RULE16
			end else begin
				raw[2*p] = cnt_q < m_eff(2*p);
				raw[2*p+1] = cnt_q < m_eff(2*p+1);
			end
			dt_use[p] = pc.combine & pc.comp & pc.dt_en; // RULE17
			dead_now[p] = dt_use[p] & ((dead_q[p] != '0) || ((raw[2*p] != prev_q[p])
				&& (dt_ticks(deadt_q[p*pwm_timer_pkg::DT_FW +: pwm_timer_pkg::DT_FW]) != '0)));
		end
		for (int f = 0; f < NF; f++) begin
			fc = pwm_timer_pkg::fault_cfg_t'(fault_q[f*pwm_timer_pkg::FAULT_FW +: 3]);
			fsel[f] = fc.en & ((fc.filt ? fflt_q[f] : fault_in[f]) ^ fc.act_low); // RULE1
		end
	end

	// Up counter wrapping to the initial value
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cnt_q <= '0;
			pacc_q <= '0;
			pcar_q <= 1'b0;
			ecar_q <= '0;
			lf_cnt_q <= '0;
			for (int i = 0; i < NC; i++) begin
				eacc_q[i] <= '0;
			end
		end else begin
			if (wrap) begin
				cnt_q <= init_q; // RULE22 RULE19
				{pcar_q, pacc_q} <= {1'b0, pacc_q} + {1'b0, modfrac_q}; // RULE12
				for (int i = 0; i < NC; i++) begin
					{ecar_q[i], eacc_q[i]} <= {1'b0, eacc_q[i]} + {1'b0, mfrac_q[i]}; // RULE13
				end
			end else if (run_q) begin
				cnt_q <= cnt_q + CNT_W'(1);
			end
			if (rp) begin
				lf_cnt_q <= take ? '0 : lf_cnt_q + pwm_timer_pkg::LFREQ_W'(1); // RULE10
			end
		end
	end

	// ============================================================
	// AXI4-Lite handshakes, one write and one read at a time
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_full_q <= 1'b0;
			w_full_q <= 1'b0;
			awready_q <= 1'b1;
			wready_q <= 1'b1;
			bvalid_q <= 1'b0;
			bresp_q <= pwm_timer_pkg::RESP_OKAY;
			waddr_q <= '0;
			wdata_q <= '0;
			wstrb_q <= '0;
			arready_q <= 1'b1;
			rvalid_q <= 1'b0;
			rdata_q <= '0;
			rresp_q <= pwm_timer_pkg::RESP_OKAY;
		end else begin
			if (s_axi_awvalid && awready_q) begin
				aw_full_q <= 1'b1;
				awready_q <= 1'b0;
				waddr_q <= s_axi_awaddr;
			end
			if (s_axi_wvalid && wready_q) begin
				w_full_q <= 1'b1;
				wready_q <= 1'b0;
				wdata_q <= s_axi_wdata;
				wstrb_q <= s_axi_wstrb;
			end
			if (do_wr) begin
				aw_full_q <= 1'b0;
				w_full_q <= 1'b0;
				bvalid_q <= 1'b1;
				bresp_q <= wr_ok ? pwm_timer_pkg::RESP_OKAY : pwm_timer_pkg::RESP_SLVERR;
			end
			if (bvalid_q && s_axi_bready) begin
				bvalid_q <= 1'b0;
				awready_q <= 1'b1;
				wready_q <= 1'b1;
			end
			if (s_axi_arvalid && arready_q) begin
				arready_q <= 1'b0;
				rvalid_q <= 1'b1;
				rdata_q <= rd_word(s_axi_araddr);
				rresp_q <= addr_ok(s_axi_araddr) ? pwm_timer_pkg::RESP_OKAY
					: pwm_timer_pkg::RESP_SLVERR;
			end
			if (rvalid_q && s_axi_rready) begin
				rvalid_q <= 1'b0;
				arready_q <= 1'b1;
			end
		end
	end

	// ============================================================
	// Control and configuration registers
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			{run_q, gtb_en_q, wpen_q, swsel_q, load_ok_bit_q} <= '0;
			lfreq_q <= '0;
			outmask_q <= '0;
			outen_q <= '0;
			pair_q <= '0;
			fault_q <= '0;
			deadt_q <= '0;
			level_q <= '0;
			relsel_q <= '0;
			chie_q <= '0;
			dmae_q <= '0;
		end else begin
			if (take && load_ok_bit_q) begin
				load_ok_bit_q <= 1'b0;
			end
			if (wr_ok) begin
				unique case (waddr_q)
					pwm_timer_pkg::OFF_CTRL: begin
						run_q <= wword[pwm_timer_pkg::CTRL_RUN];
						gtb_en_q <= wword[pwm_timer_pkg::CTRL_GTB]; // RULE2
						wpen_q <= wword[pwm_timer_pkg::CTRL_WPEN]; // RULE6
						swsel_q <= wword[pwm_timer_pkg::CTRL_SWSEL]; // RULE5
						load_ok_bit_q <= wword[pwm_timer_pkg::CTRL_LOAD_OK_BIT]; // RULE8
						lfreq_q <= wword[pwm_timer_pkg::CTRL_LF_LSB +: pwm_timer_pkg::LFREQ_W];
					end
					pwm_timer_pkg::OFF_OUTMASK: outmask_q <= wword[NC-1:0]; // RULE3
					pwm_timer_pkg::OFF_OUTEN: outen_q <= wword[NC-1:0]; // RULE4
					pwm_timer_pkg::OFF_PAIR: pair_q <= wword[$bits(pair_q)-1:0];
					pwm_timer_pkg::OFF_FAULT: fault_q <= wword[$bits(fault_q)-1:0]; // RULE1
					pwm_timer_pkg::OFF_DEADT: deadt_q <= wword[$bits(deadt_q)-1:0]; // RULE11
					pwm_timer_pkg::OFF_LEVEL: level_q <= wword[$bits(level_q)-1:0]; // RULE20
					pwm_timer_pkg::OFF_RELSEL: relsel_q <= wword[$bits(relsel_q)-1:0];
					pwm_timer_pkg::OFF_CHEN: begin
						chie_q <= wword[NC-1:0];
						dmae_q <= wword[pwm_timer_pkg::CHEN_DMA_LSB +: NC];
					end
					default: ;
				endcase
			end
		end
	end

	// ============================================================
	// Buffered values and their active copies
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			{init_buf_q, mod_buf_q, hcr_buf_q, init_q, mod_q, hcr_q} <= '0;
			modfrac_buf_q <= '0;
			modfrac_q <= '0;
			for (int i = 0; i < NC; i++) begin
				match_buf_q[i] <= '0;
				match_q[i] <= '0;
				mfrac_buf_q[i] <= '0;
				mfrac_q[i] <= '0;
			end
		end else begin
			if (wr_ok && (in_blk(waddr_q, pwm_timer_pkg::OFF_MATCH) || is_mir)) begin
				match_buf_q[widx] <= is_mir ? wword[pwm_timer_pkg::MIR_VAL_LSB +: CNT_W]
					: wword[CNT_W-1:0]; // RULE13 RULE19
				mfrac_buf_q[widx] <= is_mir ? wword[FW-1:0] : '0;
			end
			if (wr_ok && (waddr_q == pwm_timer_pkg::OFF_INIT)) begin
				init_buf_q <= wword[CNT_W-1:0]; // RULE19
			end
			if (wr_ok && (waddr_q == pwm_timer_pkg::OFF_MOD)) begin
				mod_buf_q <= wword[CNT_W-1:0];
				modfrac_buf_q <= '0;
			end
			if (wr_ok && (waddr_q == pwm_timer_pkg::OFF_MODMIR)) begin
				mod_buf_q <= wword[pwm_timer_pkg::MIR_VAL_LSB +: CNT_W]; // RULE12
				modfrac_buf_q <= wword[FW-1:0];
			end
			if (wr_ok && (waddr_q == pwm_timer_pkg::OFF_HCR) && (wword[CNT_W-1:0] != '0)) begin
				hcr_buf_q <= wword[CNT_W-1:0]; // RULE9
			end
			if (load || !run_q) begin
				init_q <= init_buf_q; // RULE8 RULE9
				mod_q <= mod_buf_q;
				modfrac_q <= modfrac_buf_q;
				hcr_q <= hcr_buf_q;
				for (int i = 0; i < NC; i++) begin
					match_q[i] <= match_buf_q[i];
					mfrac_q[i] <= mfrac_buf_q[i];
				end
			end
		end
	end

	// ============================================================
	// Sticky status flags, hardware set wins over clear
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			flag_q <= '0;
			tof_q <= 1'b0;
			faultf_q <= 1'b0;
		end else begin
			if (wr_ok && (waddr_q == pwm_timer_pkg::OFF_STAT)) begin
				flag_q <= (flag_q & ~(wdata_q[NC-1:0] & wmask[NC-1:0])) | hits;
				tof_q <= (tof_q & ~(wdata_q[pwm_timer_pkg::STAT_TOF]
					& wmask[pwm_timer_pkg::STAT_TOF])) | wrap;
				faultf_q <= (faultf_q & ~(wdata_q[pwm_timer_pkg::STAT_FAULT]
					& wmask[pwm_timer_pkg::STAT_FAULT])) | fault_act;
			end else begin
				flag_q <= (flag_q & ~(dma_ack & dmae_q)) | hits;
				tof_q <= tof_q | wrap; // RULE22
				faultf_q <= faultf_q | fault_act;
			end
		end
	end

	// ============================================================
	// Input sampling and fault filters
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			in_s1_q <= '0;
			in_s2_q <= '0;
			fflt_q <= '0;
			for (int f = 0; f < NF; f++) begin
				fcnt_q[f] <= '0;
			end
		end else begin
			in_s1_q <= ch_in;
			in_s2_q <= in_s1_q; // RULE14
			for (int f = 0; f < NF; f++) begin
				if (fault_in[f] == fflt_q[f]) begin
					fcnt_q[f] <= '0;
				end else if (fcnt_q[f] == FLT_CW'(FILT_LEN - 1)) begin
					fflt_q[f] <= fault_in[f]; // RULE1
					fcnt_q[f] <= '0;
				end else begin
					fcnt_q[f] <= fcnt_q[f] + FLT_CW'(1);
				end
			end
		end
	end

	// ============================================================
	// Dead-time counters per pair
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			prev_q <= '0;
			for (int p = 0; p < NP; p++) begin
				dead_q[p] <= '0;
			end
		end else begin
			for (int p = 0; p < NP; p++) begin
				prev_q[p] <= raw[2*p];
				if (dt_use[p] && (raw[2*p] != prev_q[p])) begin
					dead_q[p] <= dt_ticks(deadt_q[p*pwm_timer_pkg::DT_FW +: pwm_timer_pkg::DT_FW])
						- pwm_timer_pkg::DTC_W'(1); // RULE11 RULE17
				end else if (dead_q[p] != '0) begin
					dead_q[p] <= dead_q[p] - pwm_timer_pkg::DTC_W'(1);
				end
			end
		end
	end

	// ============================================================
	// Output stage: mask, fault, polarity, enable
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			out_q <= '0;
			oe_q <= '0;
			gtb_q <= 1'b0;
			dma_q <= '0;
			irq_q <= '0;
		end else begin
			for (int i = 0; i < NC; i++) begin
				logic act;
				logic [pwm_timer_pkg::LVL_W-1:0] lv;
				lv = level_q[i*pwm_timer_pkg::LVL_W +: pwm_timer_pkg::LVL_W];
				act = run_q & raw[i] & ~outmask_q[i] & ~fault_act & ~dead_now[i/2]; // RULE3
				out_q[i] <= (lv == pwm_timer_pkg::LVL_HIGH) ? act
					: (lv == pwm_timer_pkg::LVL_LOW) ? ~act : 1'b0; // RULE20
				oe_q[i] <= outen_q[i] & (lv != pwm_timer_pkg::LVL_NONE); // RULE4
			end
			gtb_q <= gtb_en_q & wrap; // RULE2
			dma_q <= flag_q & chie_q & dmae_q; // RULE7
			irq_q <= flag_q & chie_q & ~dmae_q; // RULE7
		end
	end

	assign s_axi_awready = awready_q;
	assign s_axi_wready = wready_q;
	assign s_axi_bvalid = bvalid_q;
	assign s_axi_bresp = bresp_q;
	assign s_axi_arready = arready_q;
	assign s_axi_rvalid = rvalid_q;
	assign s_axi_rdata = rdata_q;
	assign s_axi_rresp = rresp_q;
	assign ch_out = out_q;
	assign ch_oe = oe_q;
	assign gtb_out = gtb_q;
	assign dma_req = dma_q;
	assign chan_irq = irq_q;

endmodule
`default_nettype wire

// ==== testbench/pwm_load.sv ====
`timescale 1ns/1ns
`default_nettype none
// ============================================================
// Load seen by the channel pins
module pwm_load (
	// Pin side
	input wire logic [7:0] drv,
	input wire logic [7:0] oe,
	input wire logic [7:0] ext,
	output logic [7:0] pin
);
	// Driven pins follow the timer, others show the load
	always_comb begin
		for (int i = 0; i < 8; i++) begin
			pin[i] = oe[i] ? drv[i] : ext[i];
		end
	end
endmodule
`default_nettype wire

// ==== testbench/pwm_timer_props.sv ====
`timescale 1ns/1ns
`default_nettype none
// ============================================================
// Port checks of the PWM timer
module pwm_timer_props #(
	parameter int CNT_W = 16,
	parameter int FILT_LEN = 4
) (
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// Register bus
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// Pins and requests
	input wire logic [7:0] ch_oe,
	input wire logic gtb_out,
	input wire logic [7:0] dma_req,
	input wire logic [7:0] chan_irq
);
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	// Idle state right after reset
	property p_rst;
		$rose(aresetn) |-> !s_axi_bvalid && !s_axi_rvalid && ch_oe == 8'h00 && !gtb_out;
	endproperty
	a_rst: assert property (p_rst)
		else $error("outputs not idle after reset");
	// Answers after the request
	property p_bgo;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |=> ##1 s_axi_bvalid;
	endproperty
	a_bgo: assert property (p_bgo)
		else $error("write answer late");
	property p_rgo;
		s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
	endproperty
	a_rgo: assert property (p_rgo)
		else $error("read answer late");
	// Answer taken, channel free again
	property p_bend;
		s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid && s_axi_awready && s_axi_wready;
	endproperty
	a_bend: assert property (p_bend)
		else $error("write channel not freed");
	property p_rend;
		s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid && s_axi_arready;
	endproperty
	a_rend: assert property (p_rend)
		else $error("read channel not freed");
	// No new request while an answer waits
	property p_bblk;
		s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
	endproperty
	a_bblk: assert property (p_bblk)
		else $error("write taken while answer pending");
	property p_rblk;
		s_axi_rvalid |-> !s_axi_arready;
	endproperty
	a_rblk: assert property (p_rblk)
		else $error("read taken while answer pending");
	// Transfer request replaces the interrupt
	property p_irq;
		(chan_irq & dma_req) == 8'h00;
	endproperty
	a_irq: assert property (p_irq)
		else $error("interrupt beside transfer request");
endmodule
bind pwm_timer pwm_timer_props #(.CNT_W(CNT_W), .FILT_LEN(FILT_LEN)) props_u (
	.aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid),
	.s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
	.s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
	.s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
	.ch_oe(ch_oe), .gtb_out(gtb_out), .dma_req(dma_req), .chan_irq(chan_irq));
`default_nettype wire

// ==== testbench/tb_top.sv ====
`timescale 1ns/1ns
`default_nettype none
// ============================================================
// Bench of the PWM timer
module tb_top;
	typedef struct packed {
		logic [7:0] a;
		logic [31:0] d;
		logic [31:0] e;
	} row_t;
	logic aclk = 1'h0;
	logic aresetn = 1'h0;
	logic awv = 1'h0, wv = 1'h0, bry = 1'h0, arv = 1'h0, rry = 1'h0;
	logic [7:0] awa = 8'h00, ara = 8'h00, ext = 8'h00;
	logic [31:0] wd = 32'h0, rdo, rdat, hi, tk;
	logic [3:0] fin = 4'h0;
	logic [7:0] pin, out, oe, dreq, irq;
	logic [1:0] bresp, rresp, r;
	logic awr, wry, bv, arr, rv, gtb;
	int fails = 0, compares = 0;
	// Rows: offset, word written, word read back
	row_t rows [13] = '{'{8'h00, 32'h1F00, 32'h1F00}, '{8'h0C, 32'h120, 32'h120},
		'{8'h10, 32'hA5, 32'hA5}, '{8'h18, 32'h1357, 32'h1357}, '{8'h1C, 32'h7531, 32'h7531},
		'{8'h20, 32'hC3824101, 32'hC3824101}, '{8'h30, 32'h2, 32'h2}, '{8'h40, 32'h4, 32'h4},
		'{8'hFC, 32'h1, 32'h0}, '{8'h10, 32'h0, 32'h0}, '{8'h18, 32'h0, 32'h0},
		'{8'h1C, 32'h0, 32'h0}, '{8'h14, 32'h1, 32'h1}};
	// 50 MHz clock
	always #10 aclk = ~aclk;
	pwm_load load_u (.drv(out), .oe(oe), .ext(ext), .pin(pin));
	pwm_timer dut_u (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awa), .s_axi_awvalid(awv),
		.s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(4'hF), .s_axi_wvalid(wv),
		.s_axi_wready(wry), .s_axi_bresp(bresp), .s_axi_bvalid(bv), .s_axi_bready(bry),
		.s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rdo),
		.s_axi_rresp(rresp), .s_axi_rvalid(rv), .s_axi_rready(rry), .ch_in(pin),
		.ch_out(out), .ch_oe(oe), .fault_in(fin), .gtb_out(gtb), .dma_req(dreq),
		.dma_ack(8'h00), .chan_irq(irq));
	// Compare and report
	task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
		compares++;
		if (s !== e) begin
			fails++;
			$display("ERROR %s expected %h seen %h", n, e, s);
		end
	endtask
	// Bus write, channels released when taken
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge aclk);
		awa <= a;
		wd <= d;
		awv <= 1'h1;
		wv <= 1'h1;
		bry <= 1'h1;
		do begin
			@(posedge aclk);
			if (awv && awr) awv <= 1'h0;
			if (wv && wry) wv <= 1'h0;
		end while (!bv);
		r = bresp;
		bry <= 1'h0;
	endtask
	// Bus read
	task automatic rd(input logic [7:0] a);
		@(posedge aclk);
		ara <= a;
		arv <= 1'h1;
		rry <= 1'h1;
		do begin
			@(posedge aclk);
			if (arv && arr) arv <= 1'h0;
		end while (!rv);
		rdat = rdo;
		r = rresp;
		rry <= 1'h0;
	endtask
	// Channel 0 high cycles and time-base pulses in n cycles
	task automatic pw(input int n, input logic [31:0] e);
		repeat (3) @(posedge aclk);
		{hi, tk} = '0;
		repeat (n) begin
			@(posedge aclk);
			hi = hi + out[0];
			tk = tk + gtb;
		end
		chk("duty", hi, e);
	endtask
	// Verdict
	task automatic results;
		$display("compares %0d fails %0d", compares, fails);
		if (fails == 0 && compares > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask
	// Hang guard
	initial begin
		#400000;
		fails++;
		results;
	end
	// Main sequence
	initial begin
		repeat (16) @(posedge aclk);
		aresetn <= 1'h1;
		ext <= 8'h02;
		rd(8'h14);
		chk("outen", rdat, 32'h0);
		for (int i = 0; i < 13; i++) begin
			wr(rows[i].a, rows[i].d);
			chk("resp", r, rows[i].a == 8'hFC ? 2'h2 : 2'h0);
			rd(rows[i].a);
			chk("rresp", r, rows[i].a == 8'hFC ? 2'h2 : 2'h0);
			chk("reg", rdat, rows[i].e);
		end
		wr(8'h28, 32'h3FF);
		wr(8'h00, 32'h3);
		pw(100, 32'h28);
		chk("gtb", tk, 32'hA);
		rd(8'h28);
		chk("tof", rdat[9:8], 2'h1);
		rd(8'h34);
		chk("pin_in", rdat[1], 1'h1);
		wr(8'h10, 32'h1);
		pw(20, 32'h0);
		rd(8'h34);
		chk("pin_out", rdat[8], 1'h0);
		wr(8'h10, 32'h0);
		wr(8'h30, 32'h1);
		pw(100, 32'h3C);
		wr(8'h30, 32'h2);
		wr(8'h00, 32'h7);
		wr(8'h08, 32'h5);
		chk("wp", r, 2'h2);
		rd(8'h08);
		chk("mod", rdat, 32'h9);
		wr(8'h00, 32'h3);
		wr(8'h40, 32'h2);
		pw(100, 32'h28);
		wr(8'h00, 32'h13);
		repeat (20) @(posedge aclk);
		pw(100, 32'h14);
		wr(8'h40, 32'h4);
		wr(8'h00, 32'h2B);
		repeat (20) @(posedge aclk);
		pw(100, 32'h28);
		wr(8'h1C, 32'h1);
		fin <= 4'h1;
		repeat (4) @(posedge aclk);
		pw(20, 32'h0);
		rd(8'h28);
		chk("fault", rdat[9], 1'h1);
		fin <= 4'h0;
		wr(8'h14, 32'h0);
		repeat (2) @(posedge aclk);
		chk("oe", oe[0], 1'h0);
		wr(8'h2C, 32'h1);
		repeat (20) @(posedge aclk);
		chk("irq", irq[0], 1'h1);
		wr(8'h2C, 32'h101);
		repeat (3) @(posedge aclk);
		chk("dma", {dreq[0], irq[0]}, 2'h2);
		results;
	end
endmodule
`default_nettype wire
